// ---- dv/gpio_pad_model.sv ----
// Pad model: resolves each pin from port drive, outside driver and pull-up
`timescale 1ns/1ps
module gpio_pad_model (
	input wire logic i_ref_clk,
	input wire logic [1:0] i_pin_drive,
	input wire logic [1:0] i_pin_oe,
	input wire logic [1:0] i_pullup_en,
	input wire logic [1:0] i_ext_oe,
	input wire logic [1:0] i_ext_val,
	output logic [1:0] o_level
);
	// Undriven pins wander, so a stale level never passes
	logic [1:0] float_reg;
	initial float_reg = 2'h1;
	always @(posedge i_ref_clk) float_reg <= ~float_reg;
	always_comb begin
		for (int i = 0; i < 2; i++) begin
			if (i_pin_oe[i]) o_level[i] = i_pin_drive[i];
			else if (i_ext_oe[i]) o_level[i] = i_ext_val[i];
			else if (i_pullup_en[i]) o_level[i] = 1'h1;
			else o_level[i] = float_reg[i];
		end
	end
endmodule

// ---- dv/gpio_port_asserts.sv ----
// Checker for bus timing and pad outputs of the two-pin port
`timescale 1ns/1ps
module gpio_port_asserts (
	input wire logic i_ref_clk,
	input wire logic i_arst_n,
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic [31:0] o_wb_dat,
	input wire logic o_wb_ack,
	input wire logic [1:0] o_pin_drive,
	input wire logic [1:0] o_pin_oe,
	input wire logic [1:0] o_pullup_en,
	input wire logic i_subclock_osc_en,
	input wire logic i_touch_direct_out_four_en,
	input wire logic i_touch_direct_out_four
);
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (!i_arst_n);
	sequence s_taken;
		i_wb_cyc && i_wb_stb && !o_wb_ack;
	endsequence
	// Three steady cycles, so one or two register stages both settle
	sequence s_periph_steady;
		(i_touch_direct_out_four_en && !i_subclock_osc_en && $stable(i_touch_direct_out_four))[*3];
	endsequence
	a_ack_follows: assert property (s_taken |=> o_wb_ack)
		else $error("ack missing after request");
	a_ack_single: assert property (o_wb_ack |=> !o_wb_ack)
		else $error("ack longer than one cycle");
	a_idle_data_zero: assert property (!o_wb_ack |-> o_wb_dat == 32'h0000_0000)
		else $error("read data without ack");
	a_spare_bits_zero: assert property (o_wb_ack |-> o_wb_dat[31:3] == 29'h0)
		else $error("unused bits read nonzero");
	a_reset_quiet: assert property ($rose(i_arst_n) |-> o_pin_oe == 2'h0 && !o_wb_ack)
		else $error("outputs active after reset");
	a_pullup_low_off: assert property ((o_pin_oe & ~o_pin_drive & o_pullup_en) == 2'h0)
		else $error("pull-up on a low pin");
	a_osc_owns_pins: assert property (i_subclock_osc_en [*2] |-> o_pin_oe == 2'h0)
		else $error("pin driven under oscillator");
	a_periph_drives: assert property (s_periph_steady |=>
		!o_pin_oe[0] || o_pin_drive[0] == $past(i_touch_direct_out_four))
		else $error("peripheral value not on pin");
endmodule
bind two_pin_gpio_port_with_pullup gpio_port_asserts chk_i (.*);

// ---- dv/two_pin_gpio_port_with_pullup_tb_top.sv ----
// Self-checking bench for the two-pin port
`timescale 1ns/1ps
module two_pin_gpio_port_with_pullup_tb_top;
	logic clk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0, rmw = 0, sb_in = 0, sb_out = 0;
	logic osc = 0, p4e = 0, p4 = 0, p3e = 0, p3 = 0, ack;
	logic [3:0] adr = 0;
	logic [31:0] wdat = 0, rdat;
	logic [1:0] drv, oe, pu, lvl, pin_in, xoe = 0, xval = 0;
	logic [7:0] q;
	int mismatches = 0, total_checks = 0;
	typedef struct {logic w; logic [3:0] a; logic [7:0] d; logic m; logic [7:0] e;} row_t;
	row_t rows[12] = '{'{0, 4'h4, 0, 0, 8'h00}, '{0, 4'h8, 0, 0, 8'h00}, '{0, 4'h0, 0, 1, 8'h00},
		'{1, 4'h0, 8'hff, 0, 0}, '{0, 4'h0, 0, 1, 8'h06}, '{1, 4'h4, 8'hff, 0, 0},
		'{0, 4'h4, 0, 0, 8'h06}, '{0, 4'h0, 0, 0, 8'h06}, '{1, 4'h2, 8'hff, 0, 0},
		'{0, 4'h2, 0, 0, 8'h00}, '{1, 4'h8, 8'hff, 0, 0}, '{0, 4'h8, 0, 0, 8'h06}};
	two_pin_gpio_port_with_pullup dut (.i_ref_clk(clk), .i_arst_n(rst_n), .i_wb_cyc(cyc),
		.i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hf), .i_wb_dat(wdat),
		.i_rmw_read(rmw), .o_wb_dat(rdat), .o_wb_ack(ack), .i_standby_entry(sb_in),
		.i_standby_exit(sb_out), .i_pin_level(lvl), .o_pin_drive(drv), .o_pin_oe(oe),
		.o_pullup_en(pu), .i_subclock_osc_en(osc), .i_touch_direct_out_four_en(p4e),
		.i_touch_direct_out_four(p4), .i_touch_direct_out_three_en(p3e),
		.i_touch_direct_out_three(p3), .o_port_input(pin_in));
	gpio_pad_model pads (.i_ref_clk(clk), .i_pin_drive(drv), .i_pin_oe(oe),
		.i_pullup_en(pu), .i_ext_oe(xoe), .i_ext_val(xval), .o_level(lvl));
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d, input logic m);
		int n = 0;
		@(posedge clk);
		{cyc, stb, we, adr, wdat, rmw} <= {2'h3, w, a, 24'h0, d, m};
		do @(posedge clk); while (ack !== 1'h1 && ++n < 50);
		if (n == 50) mismatches++;
		q = rdat[7:0];
		{cyc, stb} <= 2'h0;
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic pulse(input logic leave);
		@(posedge clk);
		{sb_out, sb_in} <= {leave, !leave};
		@(posedge clk);
		{sb_out, sb_in} <= 2'h0;
		wt(3);
	endtask
	task automatic summarize();
		$display("checks=%0d mismatches=%0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	initial forever #2.5 clk = ~clk;
	initial begin
		#20000;
		mismatches++;
		summarize();
	end
	initial begin
		wt(8);
		rst_n <= 1;
		foreach (rows[i]) begin
			wb(rows[i].w, rows[i].a, rows[i].d, rows[i].m);
			if (!rows[i].w) chk(q, rows[i].e);
		end
		wt(2);
		chk({2'h0, oe, drv, pu}, 8'h3f);
		wb(1, 4'h0, 8'h04, 0);
		wt(2);
		chk({4'h0, drv, pu}, 8'h0a);
		wb(1, 4'h4, 0, 0);
		{xoe, xval} <= 4'h8;
		wt(8);
		chk({4'h0, pu, pin_in}, 8'h0d);
		wb(0, 4'h0, 0, 0);
		chk(q, 8'h02);
		wb(0, 4'h0, 0, 1);
		chk(q, 8'h04);
		p4e <= 1;
		wt(8);
		chk({6'h0, oe}, 8'h01);
		wb(0, 4'h0, 0, 0);
		chk(q, 8'h00);
		wb(0, 4'h0, 0, 1);
		chk(q, 8'h04);
		{p3e, p3} <= 2'h3;
		wt(8);
		chk({4'h0, oe, drv}, 8'h0e);
		wb(0, 4'h0, 0, 0);
		chk(q, 8'h04);
		{p3e, p3} <= 2'h0;
		p4e <= 0;
		xoe <= 0;
		wb(1, 4'h4, 8'h06, 0);
		wb(1, 4'hc, 8'h01, 0);
		pulse(0);
		chk({4'h0, oe, pin_in}, 8'h00);
		wb(0, 4'hc, 0, 0);
		chk(q, 8'h03);
		pulse(1);
		wb(1, 4'hc, 0, 0);
		pulse(0);
		chk({4'h0, oe, drv}, 8'h0e);
		pulse(1);
		osc <= 1;
		wt(3);
		chk({6'h0, oe}, 8'h00);
		osc <= 0;
		rst_n <= 0;
		wt(2);
		rst_n <= 1;
		wb(0, 4'h4, 0, 0);
		chk({q[5:0], oe}, 8'h00);
		summarize();
	end
endmodule

// ---- rtl/gpio_port_pkg.sv ----
// Constants shared by the two-pin general-purpose port
package gpio_port_pkg;
	// ----------------------------------------
	// Register byte offsets on the Wishbone bus
	// ----------------------------------------
	localparam logic [3:0] PORT_DATA_LATCH_OFS = 4'h0;
	localparam logic [3:0] PORT_DIRECTION_OFS = 4'h4;
	localparam logic [3:0] PORT_PULLUP_SELECT_OFS = 4'h8;
	localparam logic [3:0] STANDBY_CONTROL_OFS = 4'hC;
	// ----------------------------------------
	// Field positions and reset values
	// ----------------------------------------
	localparam int FIRST_PORT_PIN_BIT = 1;
	localparam int SECOND_PORT_PIN_BIT = 2;
	localparam int STANDBY_PIN_STATE_BIT = 0;
	localparam int STANDBY_MODE_BIT = 1;
	localparam logic [7:0] PIN_BIT_MASK = 8'h06;
	localparam logic [7:0] STANDBY_MASK = 8'h03;
	localparam logic [7:0] PORT_RESET_VALUE = 8'h00;
	localparam logic [7:0] STANDBY_RESET_VALUE = 8'h00;
endpackage

// ---- rtl/two_pin_gpio_port_with_pullup.sv ----
// Two-pin general-purpose port with pull-ups, standby isolation and Wishbone registers
//
// Local design decisions: the address map and the Wishbone slave port.
`timescale 1ns/1ps
module two_pin_gpio_port_with_pullup (
	input wire logic i_ref_clk,
	input wire logic i_arst_n,
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [3:0] i_wb_adr,
	input wire logic [3:0] i_wb_sel,
	input wire logic [31:0] i_wb_dat,
	input wire logic i_rmw_read,
	output logic [31:0] o_wb_dat,
	output logic o_wb_ack,
	input wire logic i_standby_entry,
	input wire logic i_standby_exit,
	input wire logic [1:0] i_pin_level,
	output logic [1:0] o_pin_drive,
	output logic [1:0] o_pin_oe,
	output logic [1:0] o_pullup_en,
	input wire logic i_subclock_osc_en,
	input wire logic i_touch_direct_out_four_en,
	input wire logic i_touch_direct_out_four,
	input wire logic i_touch_direct_out_three_en,
	input wire logic i_touch_direct_out_three,
	output logic [1:0] o_port_input
);
	// ----------------------------------------
	// Pin ownership
	// ----------------------------------------
	// Highest claim first; isolation must beat every driver to stop leakage
	typedef enum logic [2:0] {
		OWN_ISOLATED,
		OWN_OSCILLATOR,
		OWN_PERIPHERAL,
		OWN_PORT_OUTPUT,
		OWN_PORT_INPUT
	} pin_owner_t;

	// ----------------------------------------
	// Register state
	// ----------------------------------------
	logic [1:0] port_data_latch_reg;
	logic [1:0] port_direction_reg;
	logic [1:0] port_pullup_select_reg;
	logic standby_pin_state_bit_reg;
	logic standby_active_reg;
	logic [1:0] sync1_reg;
	logic [1:0] sync2_reg;
	logic [1:0] sync3_reg;
	logic [1:0] pin_level_reg;
	logic [1:0] periph_en;
	logic [1:0] periph_val;
	logic [1:0] drive_next;
	logic [1:0] oe_next;
	logic [1:0] pullup_next;
	logic [1:0] data_read;
	logic [31:0] rd_next;
	logic wr_stb;
	logic [1:0] wr_pins;
	logic bus_take;
	logic wr_data_latch;
	logic wr_direction;
	logic wr_pullup_select;
	logic wr_standby_control;
	pin_owner_t owner [2];

	// ----------------------------------------
	// Helper functions
	// ----------------------------------------
	function automatic logic [1:0] pin_bits(input logic [7:0] b);
		pin_bits = {b[gpio_port_pkg::SECOND_PORT_PIN_BIT], b[gpio_port_pkg::FIRST_PORT_PIN_BIT]};
	endfunction

	function automatic logic [7:0] place_pins(input logic [1:0] p);
		place_pins = {5'h00, p, 1'b0} & gpio_port_pkg::PIN_BIT_MASK;
	endfunction

	// One decode serves every register strobe
	function automatic logic reg_hit(input logic [3:0] adr, input logic [3:0] ofs);
		reg_hit = (adr == ofs);
	endfunction

	function automatic pin_owner_t pick_owner(input logic isolated, input logic osc,
		input logic periph, input logic dir);
		if (isolated) begin
			pick_owner = OWN_ISOLATED;
		end else if (osc) begin
			pick_owner = OWN_OSCILLATOR;
		end else if (periph) begin
			pick_owner = OWN_PERIPHERAL;
		end else if (dir) begin
			pick_owner = OWN_PORT_OUTPUT;
		end else begin
			pick_owner = OWN_PORT_INPUT;
		end
	endfunction

	// Latch is returned for output pins and for any read-modify-write read
	function automatic logic read_bit(input logic rmw, input logic output_pin, input logic latch,
		input logic level);
		if (rmw) begin
			read_bit = latch;
		end else if (output_pin) begin
			read_bit = latch;
		end else begin
			read_bit = level;
		end
	endfunction

	// Pull-up drops whenever the pin is actively pulled low
	function automatic logic pullup_on(input logic sel, input logic oe, input logic drv);
		pullup_on = sel && !(oe && !drv);
	endfunction

	// A change is taken only once stages two and three agree
	function automatic logic filter_bit(input logic isolated, input logic s2, input logic s3,
		input logic cur);
		if (isolated) begin
			filter_bit = 1'b0;
		end else if (s2 == s3) begin
			filter_bit = s3;
		end else begin
			filter_bit = cur;
		end
	endfunction

	// Bit one reports live isolation; writes to it are dropped
	function automatic logic [7:0] standby_byte(input logic active, input logic setting);
		standby_byte = {6'h00, active, setting} & gpio_port_pkg::STANDBY_MASK;
	endfunction

	// Only byte lane zero carries register bits
	assign bus_take = i_wb_cyc && i_wb_stb && !o_wb_ack;
	assign wr_stb = bus_take && i_wb_we && i_wb_sel[0];
	assign wr_pins = pin_bits(i_wb_dat[7:0]);

	// ----------------------------------------
	// Register write enables
	// ----------------------------------------
	assign wr_data_latch = wr_stb && reg_hit(i_wb_adr, gpio_port_pkg::PORT_DATA_LATCH_OFS);
	assign wr_direction = wr_stb && reg_hit(i_wb_adr, gpio_port_pkg::PORT_DIRECTION_OFS);
	assign wr_pullup_select = wr_stb && reg_hit(i_wb_adr, gpio_port_pkg::PORT_PULLUP_SELECT_OFS);
	assign wr_standby_control = wr_stb && reg_hit(i_wb_adr, gpio_port_pkg::STANDBY_CONTROL_OFS);

	// ----------------------------------------
	// Wishbone register writes
	// ----------------------------------------
	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			port_data_latch_reg <= pin_bits(gpio_port_pkg::PORT_RESET_VALUE);
		end else if (wr_data_latch) begin
			port_data_latch_reg <= wr_pins;
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			port_direction_reg <= pin_bits(gpio_port_pkg::PORT_RESET_VALUE);
		end else if (wr_direction) begin
			port_direction_reg <= wr_pins;
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			port_pullup_select_reg <= pin_bits(gpio_port_pkg::PORT_RESET_VALUE);
		end else if (wr_pullup_select) begin
			port_pullup_select_reg <= wr_pins;
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			standby_pin_state_bit_reg <= gpio_port_pkg::STANDBY_RESET_VALUE[0];
		end else if (wr_standby_control) begin
			standby_pin_state_bit_reg <= i_wb_dat[gpio_port_pkg::STANDBY_PIN_STATE_BIT];
		end
	end

	// ----------------------------------------
	// Standby tracking
	// ----------------------------------------
	// Setting is sampled at entry; later writes wait for the next entry
	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			standby_active_reg <= 1'b0;
		end else if (i_standby_entry) begin
			standby_active_reg <= standby_pin_state_bit_reg;
		end else if (i_standby_exit) begin
			standby_active_reg <= 1'b0;
		end
	end

	// ----------------------------------------
	// Pin input synchroniser
	// ----------------------------------------
	// Stage one may go metastable, so only stage two reads it
	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			sync1_reg <= 2'h0;
		end else begin
			sync1_reg <= i_pin_level;
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			sync2_reg <= 2'h0;
		end else begin
			sync2_reg <= sync1_reg;
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			sync3_reg <= 2'h0;
		end else begin
			sync3_reg <= sync2_reg;
		end
	end

	// Change accepted only when stages two and three agree; forced low in standby
	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			pin_level_reg <= 2'h0;
		end else begin
			for (int i = 0; i < 2; i++) begin
				pin_level_reg[i] <= filter_bit(standby_active_reg, sync2_reg[i], sync3_reg[i],
					pin_level_reg[i]);
			end
		end
	end

	// ----------------------------------------
	// Pin drive selection
	// ----------------------------------------
	// Oscillator use takes the pin off the port, analog-style, with no drive
	assign periph_en = {i_touch_direct_out_three_en, i_touch_direct_out_four_en};
	assign periph_val = {i_touch_direct_out_three, i_touch_direct_out_four};

	// Owner decode is combinational; the pads add one register of latency
	always_comb begin
		for (int i = 0; i < 2; i++) begin
			owner[i] = pick_owner(standby_active_reg, i_subclock_osc_en, periph_en[i],
				port_direction_reg[i]);
		end
	end

	always_comb begin
		drive_next = 2'h0;
		oe_next = 2'h0;
		pullup_next = 2'h0;
		for (int i = 0; i < 2; i++) begin
			unique case (owner[i])
				OWN_ISOLATED, OWN_OSCILLATOR, OWN_PORT_INPUT: begin
					oe_next[i] = 1'b0;
				end
				OWN_PERIPHERAL: begin
					oe_next[i] = 1'b1;
					drive_next[i] = periph_val[i];
				end
				OWN_PORT_OUTPUT: begin
					oe_next[i] = 1'b1;
					drive_next[i] = port_data_latch_reg[i];
				end
			endcase
			pullup_next[i] = pullup_on(port_pullup_select_reg[i], oe_next[i],
				drive_next[i]);
		end
	end

	// ----------------------------------------
	// Registered pad outputs
	// ----------------------------------------
	// outputs take the next values on every clock; only reset forces them to zero
	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_pin_drive <= 2'h0;
		end else begin
			o_pin_drive <= drive_next;
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_pin_oe <= 2'h0;
		end else begin
			o_pin_oe <= oe_next;
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_pullup_en <= 2'h0;
		end else begin
			o_pullup_en <= pullup_next;
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_port_input <= 2'h0;
		end else begin
			o_port_input <= pin_level_reg;
		end
	end

	// ----------------------------------------
	// Read path and acknowledge
	// ----------------------------------------
	always_comb begin
		for (int i = 0; i < 2; i++) begin
			data_read[i] = read_bit(i_rmw_read, port_direction_reg[i] && !periph_en[i],
				port_data_latch_reg[i], pin_level_reg[i]);
		end
		rd_next = 32'h0000_0000;
		unique case (i_wb_adr)
			gpio_port_pkg::PORT_DATA_LATCH_OFS: begin
				rd_next[7:0] = place_pins(data_read);
			end
			gpio_port_pkg::PORT_DIRECTION_OFS: begin
				rd_next[7:0] = place_pins(port_direction_reg);
			end
			gpio_port_pkg::PORT_PULLUP_SELECT_OFS: begin
				rd_next[7:0] = place_pins(port_pullup_select_reg);
			end
			gpio_port_pkg::STANDBY_CONTROL_OFS: begin
				rd_next[7:0] = standby_byte(standby_active_reg, standby_pin_state_bit_reg);
			end
			default: rd_next = 32'h0000_0000;
		endcase
	end

	// ----------------------------------------
	// Bus answer
	// ----------------------------------------
	// Unmapped addresses still ack with zero so the bus never hangs
	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_wb_ack <= 1'b0;
		end else begin
			o_wb_ack <= bus_take;
		end
	end

	// Read data is zero outside ack, so a stale byte never lingers
	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_wb_dat <= 32'h0000_0000;
		end else begin
			o_wb_dat <= (bus_take && !i_wb_we) ? rd_next : 32'h0000_0000;
		end
	end
endmodule
